//--- shared/trig_exp_pkg.sv
package trig_exp_pkg;
  // clock and derived timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam logic [5:0] US_CNT = 6'(CLK_MHZ - 1);
  localparam int EXP_DLY_NS = 500;
  localparam logic [7:0] EXP_DLY_CNT =
    8'((EXP_DLY_NS * CLK_MHZ + 999) / 1000 - 1);
  localparam int MIN_PULSE_NS = 1000;
  localparam logic [7:0] MIN_PW_CNT =
    8'((MIN_PULSE_NS * CLK_MHZ + 999) / 1000 - 1);
  localparam int EXP_MAX_S = 60;
  localparam logic [25:0] EXP_MAX_US = 26'(EXP_MAX_S * 1_000_000);
  // sensor geometry and type
  localparam logic [7:0] SENS_COLS = 8'hc8;
  localparam logic [7:0] SENS_ROWS = 8'h96;
  localparam logic SENSOR_COLOR = 1'b0;
  // register offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_EXP = 8'h08;
  localparam logic [7:0] OFS_TMR = 8'h0c;
  localparam logic [7:0] OFS_ROI = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_LINE = 8'h18;
  // control and command field positions
  localparam int F_PW = 3;
  localparam int F_ROLL = 4;
  localparam int F_FLH = 5;
  localparam int F_FLV = 6;
  localparam int F_BINH = 7;
  localparam int F_BINV = 8;
  localparam int F_DECH = 9;
  localparam int F_DECV = 10;
  localparam int F_DVAL = 11;
  localparam int F_ACQ = 12;
  localparam int C_SW = 0;
  localparam int C_NV = 1;
  // reset values
  localparam logic [25:0] EXP_RST_US = 26'h00003e8;
  localparam logic [25:0] TMR_RST_US = 26'h00186a0;
  localparam logic [15:0] LINE_RST_CYC = 16'h0320;
  // trigger sources
  localparam logic [2:0] SRC_IN0 = 3'h0;
  localparam logic [2:0] SRC_SW = 3'h4;
  localparam logic [2:0] SRC_TMR = 3'h5;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ALIGN, ST_DELAY, ST_EXPOSE, ST_ROLL
  } state_t;
endpackage : trig_exp_pkg

//--- design/sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module sync_edge #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_reg; // first stage, read only by s2
  logic [W-1:0] s2_reg; // settled level
  logic [W-1:0] s3_reg; // previous settled level

  // two-stage synchroniser then one delay for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else if (ce) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // edges come from settled stages only
  assign lvl = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule : sync_edge
`default_nettype wire

//--- design/readout_walk.sv
`timescale 1ns/1ps
`default_nettype none
module readout_walk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] x0,
  input wire logic [7:0] w,
  input wire logic [7:0] y0,
  input wire logic [7:0] h,
  input wire logic flip_h,
  input wire logic flip_v,
  input wire logic [1:0] step_x,
  input wire logic [1:0] step_y,
  input wire logic third_q,
  output logic [7:0] col,
  output logic [7:0] row,
  output logic valid,
  output logic done
);
  logic busy_reg; // walk in progress
  logic [7:0] cx_reg; // column offset inside window
  logic [7:0] cy_reg; // row offset inside window
  logic [1:0] ph_reg; // modulo-3 column phase
  logic [8:0] nx; // next column offset
  logic [8:0] ny; // next row offset

  assign nx = {1'b0, cx_reg} + {7'h00, step_x};
  assign ny = {1'b0, cy_reg} + {7'h00, step_y};

  // raster over the window, mirrored by address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cx_reg <= 8'h00;
      cy_reg <= 8'h00;
      ph_reg <= 2'h0;
      col <= 8'h00;
      row <= 8'h00;
      valid <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      valid <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        cx_reg <= 8'h00;
        cy_reg <= 8'h00;
        ph_reg <= 2'h0;
      end else if (busy_reg) begin
        // mirror by reading memory backwards
        col <= flip_h ? x0 + w - 8'h01 - cx_reg : x0 + cx_reg;
        row <= flip_v ? y0 + h - 8'h01 - cy_reg : y0 + cy_reg;
        valid <= !third_q || ph_reg == 2'h0;
        ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
        if (nx >= {1'b0, w}) begin
          cx_reg <= 8'h00;
          ph_reg <= 2'h0;
          if (ny >= {1'b0, h}) begin
            busy_reg <= 1'b0;
            done <= 1'b1;
          end else begin
            cy_reg <= ny[7:0];
          end
        end else begin
          cx_reg <= nx[7:0];
        end
      end
    end
  end
endmodule : readout_walk
`default_nettype wire

//--- design/trigger_exposure_readout_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module trigger_exposure_readout_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [trig_exp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] io_in,
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic [25:0] nv_exp_us,
  output logic nv_save,
  output logic [25:0] nv_save_data,
  output logic pix_reset_all,
  output logic integrate_all,
  output logic readout_start,
  output logic row_reset,
  output logic [7:0] row_reset_idx,
  output logic row_read,
  output logic [7:0] row_read_idx,
  output logic bin_h_en,
  output logic bin_v_en,
  output logic [7:0] rd_col,
  output logic [7:0] rd_row,
  output logic rd_valid,
  output logic rd_done
);
  import trig_exp_pkg::*;

  logic [2:0] src_reg; // trigger source select
  logic pw_reg; // pulse width exposure mode
  logic roll_reg; // rolling shutter
  logic flh_reg; // horizontal mirror
  logic flv_reg; // vertical mirror
  logic dech_reg; // column decimation
  logic decv_reg; // row decimation
  logic dval_reg; // qualifier enable
  logic acq_reg; // timed trigger running
  logic [25:0] exp_reg; // exposure length in us
  logic [25:0] tmr_reg; // timed trigger period in us
  logic [31:0] roi_reg; // window: x0,w,y0,h
  logic [15:0] line_reg; // line time in cycles
  logic sw_trig_reg; // software trigger pulse
  logic nv_loaded_reg; // stored exposure taken
  logic cfg_wr_seen; // any control write since reset
  state_t st_reg; // sequencer state
  logic [25:0] exp_sh; // exposure latched per frame
  logic pw_sh; // pulse width latched per frame
  logic [25:0] et_reg; // elapsed exposure in us
  logic [7:0] dly_reg; // fixed start delay count
  logic [7:0] pwc_reg; // pulse width minimum count
  logic [15:0] lc_reg; // line time count
  logic [7:0] rst_row; // next row to reset
  logic [7:0] rd_row_n; // next row to read
  logic expd_reg; // rolling exposure elapsed
  logic [15:0] frames_reg; // completed frames
  logic [5:0] pre_reg; // us prescaler
  logic [25:0] tcnt_reg; // timed trigger count
  logic tmr_trig_reg; // timed trigger pulse
  logic [5:0] s_lvl; // synced io, fval, lval
  logic [5:0] s_rise;
  logic [5:0] s_fall;
  logic us_tick;
  logic line_tick;
  logic trig_rise;
  logic trig_lvl;
  logic wr_en;
  logic hit;
  logic [31:0] rd_mux;
  logic [1:0] step_x;
  logic [1:0] step_y;

  // pins come from outside the clock domain
  sync_edge #(.W(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din({line_valid, frame_valid, io_in}),
    .lvl(s_lvl),
    .rise(s_rise),
    .fall(s_fall)
  );

  // clamp a written exposure to the allowed range
  function automatic logic [25:0] clamp_exp(input logic [31:0] v);
    clamp_exp = (v > {6'h00, EXP_MAX_US}) ? EXP_MAX_US : v[25:0];
  endfunction : clamp_exp

  // apb decode: one wait state, write at pready edge
  assign wr_en = psel && penable && pready && pwrite;
  assign hit = paddr inside {OFS_CTRL, OFS_CMD, OFS_EXP, OFS_TMR,
                             OFS_ROI, OFS_STAT, OFS_LINE};

  // read mux
  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      OFS_CTRL: rd_mux = {19'h0, acq_reg, dval_reg, decv_reg, dech_reg,
                          bin_v_en, bin_h_en, flv_reg, flh_reg, roll_reg,
                          pw_reg, src_reg};
      OFS_EXP: rd_mux = {6'h0, exp_reg};
      OFS_TMR: rd_mux = {6'h0, tmr_reg};
      OFS_ROI: rd_mux = roi_reg;
      OFS_STAT: rd_mux = {11'h0, frames_reg, s_lvl[4], s_lvl[5], st_reg};
      OFS_LINE: rd_mux = {16'h0, line_reg};
      default: rd_mux = 32'h0; // command and unmapped read zero
    endcase
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= !hit;
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // control register: writes act at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= SRC_IN0;
      {pw_reg, roll_reg, flh_reg, flv_reg} <= 4'h0;
      {bin_h_en, bin_v_en, dech_reg, decv_reg} <= 4'h0;
      {dval_reg, acq_reg, cfg_wr_seen} <= 3'h0;
    end else if (ce && wr_en && paddr == OFS_CTRL) begin
      cfg_wr_seen <= 1'b1;
      src_reg <= pwdata[2:0];
      pw_reg <= pwdata[F_PW];
      roll_reg <= pwdata[F_ROLL];
      flh_reg <= pwdata[F_FLH];
      flv_reg <= pwdata[F_FLV];
      bin_h_en <= pwdata[F_BINH] && !SENSOR_COLOR;
      bin_v_en <= pwdata[F_BINV] && !SENSOR_COLOR;
      dech_reg <= pwdata[F_DECH];
      decv_reg <= pwdata[F_DECV];
      dval_reg <= pwdata[F_DVAL];
      acq_reg <= pwdata[F_ACQ];
    end
  end

  // exposure, timer, window and line registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_reg <= EXP_RST_US;
      nv_loaded_reg <= 1'b0;
      tmr_reg <= TMR_RST_US;
      roi_reg <= {SENS_ROWS, 8'h00, SENS_COLS, 8'h00};
      line_reg <= LINE_RST_CYC;
    end else if (ce) begin
      if (!nv_loaded_reg) begin
        nv_loaded_reg <= 1'b1;
        exp_reg <= clamp_exp({6'h00, nv_exp_us});
      end else if (wr_en) begin
        unique case (paddr)
          OFS_EXP: exp_reg <= clamp_exp(pwdata);
          OFS_TMR: tmr_reg <= pwdata[25:0];
          OFS_ROI: roi_reg <= pwdata;
          OFS_LINE: line_reg <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // command strobes: software trigger and nonvolatile save
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_trig_reg <= 1'b0;
      nv_save <= 1'b0;
      nv_save_data <= 26'h0;
    end else if (ce) begin
      sw_trig_reg <= wr_en && paddr == OFS_CMD && pwdata[C_SW];
      nv_save <= wr_en && paddr == OFS_CMD && pwdata[C_NV];
      nv_save_data <= exp_reg;
    end
  end

  // microsecond prescaler and timed trigger
  assign us_tick = pre_reg == US_CNT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 6'h0;
      tcnt_reg <= 26'h0;
      tmr_trig_reg <= 1'b0;
    end else if (ce) begin
      pre_reg <= us_tick ? 6'h0 : pre_reg + 6'h1;
      tmr_trig_reg <= 1'b0;
      if (!acq_reg) begin
        tcnt_reg <= 26'h0;
      end else if (us_tick) begin
        if (tcnt_reg >= tmr_reg) begin
          tcnt_reg <= 26'h0;
          tmr_trig_reg <= 1'b1;
        end else begin
          tcnt_reg <= tcnt_reg + 26'h1;
        end
      end
    end
  end

  // trigger selection
  always_comb begin
    trig_lvl = 1'b0;
    trig_rise = 1'b0;
    if (src_reg < SRC_SW) begin
      trig_lvl = s_lvl[src_reg[1:0]];
      trig_rise = s_rise[src_reg[1:0]];
    end else if (src_reg == SRC_SW) begin
      trig_rise = sw_trig_reg;
    end else if (src_reg == SRC_TMR) begin
      trig_rise = tmr_trig_reg;
    end
  end

  assign line_tick = lc_reg >= line_reg;

  // capture sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE;
      {exp_sh, et_reg} <= 52'h0;
      {pw_sh, expd_reg} <= 2'h0;
      {dly_reg, pwc_reg, rst_row, rd_row_n} <= 32'h0;
      lc_reg <= 16'h0;
      frames_reg <= 16'h0;
      {pix_reset_all, integrate_all, readout_start} <= 3'h0;
      {row_reset, row_read} <= 2'h0;
      {row_reset_idx, row_read_idx} <= 16'h0;
    end else if (ce) begin
      pix_reset_all <= 1'b0;
      readout_start <= 1'b0;
      row_reset <= 1'b0;
      row_read <= 1'b0;
      unique case (st_reg)
        ST_IDLE: begin
          if (trig_rise) begin
            exp_sh <= exp_reg;
            pw_sh <= pw_reg && !roll_reg;
            dly_reg <= 8'h0;
            st_reg <= s_lvl[4] ? ST_ALIGN : ST_DELAY;
          end
        end
        ST_ALIGN, ST_DELAY: begin
          dly_reg <= dly_reg + 8'h1;
          if ((st_reg == ST_ALIGN && (s_fall[5] || !s_lvl[4])) ||
              (st_reg == ST_DELAY && dly_reg == EXP_DLY_CNT)) begin
            et_reg <= 26'h0;
            pwc_reg <= 8'h0;
            lc_reg <= 16'h0;
            {rst_row, rd_row_n, expd_reg} <= 17'h0;
            if (roll_reg) begin
              st_reg <= ST_ROLL;
            end else begin
              st_reg <= ST_EXPOSE;
              pix_reset_all <= 1'b1;
              integrate_all <= 1'b1;
            end
          end
        end
        ST_EXPOSE: begin
          if (us_tick) et_reg <= et_reg + 26'h1;
          if (pwc_reg != MIN_PW_CNT) pwc_reg <= pwc_reg + 8'h1;
          // pulse width ends on trigger low, not before minimum
          if (pw_sh ? (!trig_lvl && pwc_reg == MIN_PW_CNT)
                    : (et_reg >= exp_sh)) begin
            integrate_all <= 1'b0;
            readout_start <= 1'b1;
            frames_reg <= frames_reg + 16'h1;
            st_reg <= ST_IDLE;
          end
        end
        ST_ROLL: begin
          // frame time is exposure plus full-sensor scan
          lc_reg <= line_tick ? 16'h0 : lc_reg + 16'h1;
          if (us_tick && !expd_reg) begin
            et_reg <= et_reg + 26'h1;
          end
          if (et_reg >= exp_sh) expd_reg <= 1'b1;
          if (line_tick && rst_row != SENS_ROWS) begin
            row_reset <= 1'b1;
            row_reset_idx <= rst_row;
            rst_row <= rst_row + 8'h1;
          end
          if (line_tick && expd_reg && rd_row_n != SENS_ROWS) begin
            row_read <= 1'b1;
            row_read_idx <= rd_row_n;
            rd_row_n <= rd_row_n + 8'h1;
          end
          if (rd_row_n == SENS_ROWS) begin
            frames_reg <= frames_reg + 16'h1;
            st_reg <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // column and row stride from binning and decimation
  always_comb begin
    step_x = 2'h1;
    step_y = 2'h1;
    if (dech_reg) step_x = SENSOR_COLOR ? 2'h3 : 2'h2;
    else if (bin_h_en) step_x = 2'h2;
    if (decv_reg) step_y = SENSOR_COLOR ? 2'h3 : 2'h2;
    else if (bin_v_en) step_y = 2'h2;
  end

  // frame memory walk once the sensor frame ends
  readout_walk u_walk (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(s_fall[4]),
    .x0(roi_reg[7:0]),
    .w(roi_reg[15:8]),
    .y0(roi_reg[23:16]),
    .h(roi_reg[31:24]),
    .flip_h(flh_reg),
    .flip_v(flv_reg),
    .step_x(step_x),
    .step_y(step_y),
    .third_q(dval_reg && bin_h_en && bin_v_en),
    .col(rd_col),
    .row(rd_row),
    .valid(rd_valid),
    .done(rd_done)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  src_default_a: assert property (!cfg_wr_seen |-> src_reg == SRC_IN0)
    else $error("trigger source not first input after reset");
  overlap_wait_a: assert property (
    ce && st_reg == ST_IDLE && trig_rise && s_lvl[4] |=>
    st_reg == ST_ALIGN && !integrate_all)
    else $error("overlapped trigger did not wait for line end");
  no_overlap_a: assert property (
    ce && st_reg == ST_IDLE && trig_rise && !s_lvl[4] |=>
    st_reg == ST_DELAY)
    else $error("trigger outside frame not delayed");
  delay_end_a: assert property (
    ce && st_reg == ST_DELAY && dly_reg == EXP_DLY_CNT && !roll_reg |=>
    pix_reset_all && integrate_all)
    else $error("exposure not started after fixed delay");
  busy_ignore_a: assert property (
    st_reg == ST_EXPOSE |=> st_reg inside {ST_EXPOSE, ST_IDLE})
    else $error("trigger accepted during exposure");
  shadow_hold_a: assert property (
    st_reg == ST_EXPOSE |=> $stable(exp_sh))
    else $error("exposure length changed mid frame");
  prog_len_a: assert property (
    ce && st_reg == ST_EXPOSE && !pw_sh && et_reg < exp_sh |=>
    integrate_all)
    else $error("programmed exposure ended early");
  roll_no_pw_a: assert property (
    ce && st_reg == ST_IDLE && trig_rise && roll_reg |=> !pw_sh)
    else $error("pulse width exposure in rolling mode");
  color_bin_a: assert property (
    SENSOR_COLOR |-> !bin_h_en && !bin_v_en)
    else $error("binning enabled on color sensor");
  global_end_a: assert property (
    $rose(readout_start) |-> !integrate_all && $past(integrate_all))
    else $error("readout started without global stop");
endmodule : trigger_exposure_readout_ctrl
`default_nettype wire

//--- sim/sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural sensor: one frame of six lines per readout request
module sensor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic frame_valid,
  output logic line_valid
);
  logic [7:0] cnt; // cycles left in the frame
  // frame counter, restarted by each readout request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
    end else if (start) begin
      cnt <= 8'h54;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // frame valid spans all lines, so a trigger can overlap it
  assign frame_valid = (cnt != 8'h00);
  // each line of 14 cycles ends with a low gap of five
  assign line_valid = frame_valid && ((cnt % 8'h0e) > 8'h04);
endmodule : sensor_model
`default_nettype wire

//--- sim/tb_trigger_exposure_readout_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_trigger_exposure_readout_ctrl;
  import trig_exp_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, row_reset_idx, row_read_idx, rd_col, rd_row;
  logic [31:0] pwdata, prdata;
  logic [3:0] io_in;
  logic [25:0] nv_exp_us, nv_save_data;
  logic frame_valid, line_valid, nv_save, pix_reset_all, integrate_all;
  logic readout_start, row_reset, row_read, bin_h_en, bin_v_en;
  logic rd_valid, rd_done;
  logic lv_d = 1'b0; // line valid one edge ago
  int n_fail = 0, check_count = 0, lsince = 0;
  int nvs = 0, nrr = 0, nrd = 0, npr = 0; // pulse counts

  trigger_exposure_readout_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_in(io_in),
    .frame_valid(frame_valid), .line_valid(line_valid),
    .nv_exp_us(nv_exp_us), .nv_save(nv_save), .nv_save_data(nv_save_data),
    .pix_reset_all(pix_reset_all), .integrate_all(integrate_all),
    .readout_start(readout_start), .row_reset(row_reset),
    .row_reset_idx(row_reset_idx), .row_read(row_read),
    .row_read_idx(row_read_idx), .bin_h_en(bin_h_en), .bin_v_en(bin_v_en),
    .rd_col(rd_col), .rd_row(rd_row), .rd_valid(rd_valid), .rd_done(rd_done)
  );
  sensor_model u_sensor (
    .pclk(pclk), .presetn(presetn), .start(readout_start),
    .frame_valid(frame_valid), .line_valid(line_valid)
  );
  // 25 ns clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // pulse counters and cycles since the last line-valid fall
  always @(posedge pclk) begin
    lv_d <= line_valid;
    lsince <= (lv_d && !line_valid) ? 0 : lsince + 1;
    if (nv_save === 1'b1) nvs <= nvs + 1;
    if (row_reset === 1'b1) nrr <= nrr + 1;
    if (row_read === 1'b1) nrd <= nrd + 1;
    if (pix_reset_all === 1'b1) npr <= npr + 1;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // window check on a measured cycle count
  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask : rng
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask : rd
  // trigger pulse on the first input line, never below minimum width
  task automatic trig(input int w);
    io_in[0] <= 1'b1;
    repeat (w) @(posedge pclk);
    io_in[0] <= 1'b0;
  endtask : trig
  // cycles to exposure start, exposure length, line-fall distance
  task automatic expose(input int lim, output int d, output int l,
                        output int ls);
    d = 0;
    l = 0;
    while (integrate_all !== 1'b1 && d < lim) begin
      @(posedge pclk);
      d++;
    end
    ls = lsince;
    while (integrate_all === 1'b1 && l < 5000) begin
      @(posedge pclk);
      l++;
    end
  endtask : expose
  // pixel count and first column of the next readout walk
  task automatic walk(output int n, output logic [7:0] c0);
    int k;
    n = 0;
    k = 0;
    c0 = 8'hff;
    while (rd_done !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
      if (rd_valid === 1'b1 && n == 0) c0 = rd_col;
      if (rd_valid === 1'b1) n++;
    end
  endtask : walk
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    summarize();
  end
  // main sequence
  initial begin
    int d, l, ls, n, k, p0;
    logic [31:0] q;
    logic e;
    logic [7:0] c0;
    {presetn, psel, penable, pwrite, paddr, pwdata, io_in} = '0;
    ce = 1'b1;
    nv_exp_us = 26'h0000005;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_EXP, 32'h5);
    rd(OFS_TMR, 32'h000186a0);
    rd(OFS_LINE, 32'h00000320);
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    wr(OFS_ROI, 32'h02000400);
    $display("test registers done");
    fork trig(60); expose(2000, d, l, ls); join
    rng(d, 20, 28);
    rng(l, 160, 203);
    chk(npr, 32'h1);
    walk(n, c0);
    chk(n, 32'h8);
    chk(32'(c0), 32'h0);
    $display("test hardware trigger done");
    wr(OFS_EXP, 32'ha);
    rd(OFS_EXP, 32'ha);
    fork
      begin
        trig(60);
        repeat (100) @(posedge pclk);
        trig(60);
      end
      expose(2000, d, l, ls);
    join
    rng(l, 360, 403);
    repeat (2) @(posedge pclk);
    fork trig(60); expose(2000, d, l, ls); join
    rng(ls, 1, 8);
    $display("test overlap done");
    wr(OFS_CTRL, 32'h24);
    fork trig(60); expose(100, d, l, ls); join
    rng(d, 100, 100);
    fork wr(OFS_CMD, 32'h1); expose(2000, d, l, ls); join
    rng(d, 20, 30);
    walk(n, c0);
    chk(32'(c0), 32'h3);
    wr(OFS_CTRL, 32'ha4);
    @(posedge pclk);
    chk(32'(bin_h_en), 32'h1);
    fork wr(OFS_CMD, 32'h1); expose(2000, d, l, ls); join
    walk(n, c0);
    chk(n, 32'h4);
    $display("test software trigger done");
    wr(OFS_CTRL, 32'h08);
    fork trig(240); expose(2000, d, l, ls); join
    rng(l, 205, 230);
    wr(OFS_CMD, 32'h2);
    repeat (2) @(posedge pclk);
    chk(nvs, 32'h1);
    chk(32'(nv_save_data), 32'h0000000a);
    $display("test pulse width done");
    wr(OFS_LINE, 32'h4);
    wr(OFS_CTRL, 32'h18);
    p0 = npr;
    k = 0;
    trig(60);
    while (nrd < 150 && k < 8000) begin
      @(posedge pclk);
      k++;
    end
    rng(k, 1050, 1160);
    chk(nrd, 32'd150);
    chk(nrr, 32'd150);
    chk(npr, p0);
    chk(32'(row_reset_idx), 32'd149);
    chk(32'(row_read_idx), 32'd149);
    $display("test rolling done");
    wr(OFS_ROI, 32'h04000800);
    wr(OFS_CTRL, 32'h9c4);
    @(posedge pclk);
    chk(32'(bin_v_en), 32'h1);
    fork wr(OFS_CMD, 32'h1); expose(2000, d, l, ls); join
    walk(n, c0);
    chk(n, 32'h4);
    chk(32'(rd_row), 32'h1);
    wr(OFS_CTRL, 32'h604);
    fork wr(OFS_CMD, 32'h1); expose(2000, d, l, ls); join
    walk(n, c0);
    chk(n, 32'h8);
    chk(32'(rd_row), 32'h2);
    $display("test binning and decimation done");
    wr(OFS_TMR, 32'h14);
    wr(OFS_CTRL, 32'h1005);
    expose(2000, d, l, ls);
    rng(d, 822, 863);
    wr(OFS_CTRL, 32'h0);
    $display("test timed trigger done");
    summarize();
  end
endmodule : tb_trigger_exposure_readout_ctrl
`default_nettype wire
